//--- awg_trigger_marker_unit.sv
// trigger and marker unit of the waveform sequencer: input trigger waits,
// trigger output register, marker and sample output stage, config registers
// assumes: sequencer core holds an instruction until instrReady, playback engine
// streams words on wordValid cycles after playStart and flags the last one
//
// Functional notes
// - four trigger inputs, each with a freely selectable internal or external source.
// - each input has a selectable active slope; rising means low-to-high counts.
// - wait-for-edge halts instruction issue until an edge on the addressed input.
// - a wait before each playback in a loop paces playbacks by trigger events.
// - waveform words are 16 bits: 14 analog bits, 2 marker bits.
// - marker outputs follow each word, aligned with that word's analog sample.
// - marker field 0 none, 1 marker one, 2 marker two, 3 both high.
// - load-trigger puts a 4-bit value on outputs, bit 0 to output one.
// - wait-playback-end blocks all later instructions until playback fully ends.
// - trigger load just before playback start changes outputs at first sample.
// - playback start never blocks; following instructions issue during playback, except a load while an aligned load awaits its first sample.
// - sequencer advances one clock per step; timed waits count clock periods.
`timescale 1ns/10ps

module awg_trigger_marker_unit #(
    parameter int NEXT = 4,
    parameter int NINT = 4,
    parameter int SELW = 3
) (
    input wire logic clk,
    input wire logic srst,
    // register port
    input wire logic [atm_pkg::ADDR_W-1:0] regAddr,
    input wire logic [atm_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [atm_pkg::DATA_W-1:0] regRdData,
    // trigger sources
    input wire logic [NEXT-1:0] extTrigPins,
    input wire logic [NINT-1:0] intTrigSrc,
    // instruction port from the sequencer core
    input wire logic instrValid,
    input wire atm_pkg::atm_op_t instrOp,
    input wire logic [atm_pkg::ARG_W-1:0] instrArg,
    output logic instrReady,
    // playback engine
    output logic playStart,
    input wire logic wordValid,
    input wire logic [atm_pkg::WORD_W-1:0] wordData,
    input wire logic wordLast,
    // outputs
    output logic [atm_pkg::ANALOG_W-1:0] analogOut,
    output logic [atm_pkg::MARKER_W-1:0] markerOut,
    output logic [atm_pkg::NUM_TRIG-1:0] triggerOut
);

    localparam int NSRC = NEXT + NINT;
    localparam int NT = atm_pkg::NUM_TRIG;

    // ------------------------------------------------------------------
    // pin synchronisers and trigger channels
    // ------------------------------------------------------------------
    logic [NEXT-1:0] sync1_q;
    logic [NEXT-1:0] sync2_q;
    logic [NSRC-1:0] srcLevels;
    logic [SELW-1:0] cfgSel_q [NT];
    logic [SELW-1:0] cfgSel_d [NT];
    atm_pkg::atm_slope_t cfgSlope_q [NT];
    atm_pkg::atm_slope_t cfgSlope_d [NT];
    logic [NT-1:0] chanEdge;

    // two flops before any logic sees a pin
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= extTrigPins;
            sync2_q <= sync1_q;
        end
    end

    assign srcLevels = {intTrigSrc, sync2_q};

    atm_trig_if #(.SELW(SELW)) tif [NT] ();

    for (genvar g = 0; g < NT; g++) begin : gChan
        assign tif[g].srcSel = cfgSel_q[g];
        assign tif[g].slope = cfgSlope_q[g];
        assign chanEdge[g] = tif[g].edgeSeen;
        atm_trig_channel #(.NSRC(NSRC), .SELW(SELW)) uChan (
            .clk(clk),
            .srst(srst),
            .srcLevels(srcLevels),
            .tif(tif[g])
        );
    end

    // ------------------------------------------------------------------
    // sequencer wait machine and trigger output staging
    // ------------------------------------------------------------------
    atm_pkg::atm_state_t state_q;
    atm_pkg::atm_state_t state_d;
    logic [1:0] waitCh_q;
    logic [1:0] waitCh_d;
    logic [atm_pkg::ARG_W-1:0] cyc_q;
    logic [atm_pkg::ARG_W-1:0] cyc_d;
    logic [NT-1:0] trigNext_q;
    logic [NT-1:0] trigNext_d;
    logic trigPend_q;
    logic trigPend_d;
    logic armAlign_q;
    logic armAlign_d;
    logic [NT-1:0] trigOut_q;
    logic [NT-1:0] trigOut_d;
    logic busy_q;
    logic busy_d;
    logic take;
    logic takeStart;
    logic takeLoad;

    // a load is held off while an earlier one still waits for its first sample
    assign instrReady = (state_q == atm_pkg::ST_IDLE)
                        && !(armAlign_q && instrOp == atm_pkg::OP_LOAD_TRIG);
    assign take = instrValid && instrReady;
    assign takeStart = take && instrOp == atm_pkg::OP_START_PLAY;
    assign takeLoad = take && instrOp == atm_pkg::OP_LOAD_TRIG;
    assign playStart = takeStart;

    // next state of the wait machine
    always_comb begin
        state_d = state_q;
        waitCh_d = waitCh_q;
        cyc_d = cyc_q;
        case (state_q)
            atm_pkg::ST_IDLE: begin
                if (take) begin
                    case (instrOp)
                        atm_pkg::OP_WAIT_EDGE: begin
                            waitCh_d = instrArg[1:0];
                            state_d = atm_pkg::ST_WAIT_EDGE;
                        end
                        atm_pkg::OP_WAIT_END: begin
                            state_d = atm_pkg::ST_WAIT_END;
                        end
                        atm_pkg::OP_WAIT_CYC: begin
                            cyc_d = instrArg;
                            if (instrArg != '0) begin
                                state_d = atm_pkg::ST_WAIT_CYC;
                            end
                        end
                        default: state_d = atm_pkg::ST_IDLE;
                    endcase
                end
            end
            atm_pkg::ST_WAIT_EDGE: begin
                // only edges after the wait began count
                if (chanEdge[waitCh_q]) begin
                    state_d = atm_pkg::ST_IDLE;
                end
            end
            atm_pkg::ST_WAIT_END: begin
                if (!busy_q) begin
                    state_d = atm_pkg::ST_IDLE;
                end
            end
            atm_pkg::ST_WAIT_CYC: begin
                cyc_d = cyc_q - 16'h0001;
                if (cyc_q == 16'h0001) begin
                    state_d = atm_pkg::ST_IDLE;
                end
            end
            default: state_d = atm_pkg::ST_IDLE;
        endcase
    end

    // trigger output staging: a load waits one cycle to see whether a start follows,
    // costing one cycle of latency on a plain load but aligning it to playback
    always_comb begin
        trigNext_d = trigNext_q;
        trigPend_d = trigPend_q;
        armAlign_d = armAlign_q;
        trigOut_d = trigOut_q;
        if (armAlign_q && wordValid) begin
            trigOut_d = trigNext_q;
            armAlign_d = 1'b0;
        end
        if (trigPend_q) begin
            trigPend_d = 1'b0;
            if (takeStart) begin
                armAlign_d = 1'b1;
            end else begin
                trigOut_d = trigNext_q;
            end
        end
        if (takeLoad) begin
            trigNext_d = instrArg[NT-1:0];
            trigPend_d = 1'b1;
        end
    end

    // playback busy: the set from a new start wins over the clear of the last word
    always_comb begin
        busy_d = busy_q;
        if (wordValid && wordLast) begin
            busy_d = 1'b0;
        end
        if (takeStart) begin
            busy_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= atm_pkg::ST_IDLE;
            waitCh_q <= 2'h0;
            cyc_q <= '0;
            trigNext_q <= atm_pkg::RST_TRIG_OUT;
            trigPend_q <= 1'b0;
            armAlign_q <= 1'b0;
            trigOut_q <= atm_pkg::RST_TRIG_OUT;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            waitCh_q <= waitCh_d;
            cyc_q <= cyc_d;
            trigNext_q <= trigNext_d;
            trigPend_q <= trigPend_d;
            armAlign_q <= armAlign_d;
            trigOut_q <= trigOut_d;
            busy_q <= busy_d;
        end
    end

    assign triggerOut = trigOut_q;

    // ------------------------------------------------------------------
    // sample and marker output stage
    // ------------------------------------------------------------------
    logic [atm_pkg::ANALOG_W-1:0] analog_q;
    logic [atm_pkg::ANALOG_W-1:0] analog_d;
    logic [atm_pkg::MARKER_W-1:0] marker_q;
    logic [atm_pkg::MARKER_W-1:0] marker_d;

    // both fields of a word land in the same edge; markers hold between words
    always_comb begin
        analog_d = analog_q;
        marker_d = marker_q;
        if (wordValid) begin
            analog_d = wordData[atm_pkg::WORD_W-1:atm_pkg::MARKER_W];
            marker_d = wordData[atm_pkg::MARKER_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            analog_q <= '0;
            marker_q <= atm_pkg::RST_MARKER;
        end else begin
            analog_q <= analog_d;
            marker_q <= marker_d;
        end
    end

    assign analogOut = analog_q;
    assign markerOut = marker_q;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    logic [atm_pkg::DATA_W-1:0] rd_q;
    logic [atm_pkg::DATA_W-1:0] rd_d;
    logic [atm_pkg::DATA_W-1:0] status;

    assign status = {22'h0, state_q == atm_pkg::ST_WAIT_CYC,
                     state_q == atm_pkg::ST_WAIT_END, state_q == atm_pkg::ST_WAIT_EDGE,
                     busy_q, marker_q, trigOut_q};

    // channel config writes and registered read data, zero outside a read answer
    always_comb begin
        rd_d = '0;
        for (int i = 0; i < NT; i++) begin
            cfgSel_d[i] = cfgSel_q[i];
            cfgSlope_d[i] = cfgSlope_q[i];
            if (regWr && regAddr == atm_pkg::OFS_CHAN_CFG0 + 8'(i)) begin
                cfgSel_d[i] = regWrData[atm_pkg::CFG_SEL_LSB +: SELW];
                cfgSlope_d[i] = atm_pkg::atm_slope_t'(regWrData[atm_pkg::CFG_SLOPE_LSB +: 2]);
            end
            if (regRd && regAddr == atm_pkg::OFS_CHAN_CFG0 + 8'(i)) begin
                rd_d[atm_pkg::CFG_SEL_LSB +: SELW] = cfgSel_q[i];
                rd_d[atm_pkg::CFG_SLOPE_LSB +: 2] = cfgSlope_q[i];
            end
        end
        if (regRd && regAddr == atm_pkg::OFS_STATUS) begin
            rd_d = status;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_q <= '0;
            for (int i = 0; i < NT; i++) begin
                cfgSel_q[i] <= '0;
                cfgSlope_q[i] <= atm_pkg::RST_SLOPE;
            end
        end else begin
            rd_q <= rd_d;
            for (int i = 0; i < NT; i++) begin
                cfgSel_q[i] <= cfgSel_d[i];
                cfgSlope_q[i] <= cfgSlope_d[i];
            end
        end
    end

    assign regRdData = rd_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_EDGE_WAIT_HOLDS: assert property (
        (state_q == atm_pkg::ST_WAIT_EDGE && !chanEdge[waitCh_q]) |=> !instrReady)
        else $error("instruction issued before trigger edge");

    AST_EDGE_RELEASES: assert property (
        (state_q == atm_pkg::ST_WAIT_EDGE && chanEdge[waitCh_q]) |=> state_q == atm_pkg::ST_IDLE)
        else $error("trigger edge did not release the wait");

    AST_END_WAIT_BLOCKS: assert property (
        (state_q == atm_pkg::ST_WAIT_END && busy_q) |-> !instrReady ##1 !takeLoad)
        else $error("instruction issued during playback end wait");

    AST_START_NOBLOCK: assert property (
        takeStart |=> state_q == atm_pkg::ST_IDLE && busy_q)
        else $error("playback start blocked the sequencer");

    AST_WORD_SPLIT: assert property (
        wordValid |=> analogOut == $past(wordData[15:2]) && markerOut == $past(wordData[1:0]))
        else $error("analog and marker fields misplaced");

    AST_MARKER_ALIGN: assert property (
        !wordValid |=> $stable(markerOut) && $stable(analogOut))
        else $error("marker changed without a sample");

    AST_TRIG_LOAD: assert property (
        (takeLoad ##1 !takeStart) |=> triggerOut == $past(instrArg[3:0], 2))
        else $error("trigger outputs did not take loaded value");

    AST_TRIG_ALIGN: assert property (
        (armAlign_q && wordValid) |=> triggerOut == $past(trigNext_q) && !armAlign_q)
        else $error("trigger edge not aligned to first sample");

    AST_TIMED_WAIT: assert property (
        (take && instrOp == atm_pkg::OP_WAIT_CYC && instrArg == 16'h0003)
        |=> (state_q == atm_pkg::ST_WAIT_CYC) [*3] ##1 state_q == atm_pkg::ST_IDLE)
        else $error("timed wait length wrong");

    AST_RESET_LOW: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> triggerOut == 4'h0 && markerOut == 2'h0 && state_q == atm_pkg::ST_IDLE)
        else $error("outputs not cleared by reset");

    COV_EDGE_THEN_START: cover property (
        state_q == atm_pkg::ST_WAIT_EDGE ##1 state_q == atm_pkg::ST_IDLE ##[0:4] takeStart);
    COV_LOAD_THEN_START: cover property (takeLoad ##1 takeStart ##[1:20] armAlign_q && wordValid);
    COV_WAIT_END: cover property (state_q == atm_pkg::ST_WAIT_END && busy_q ##[1:50] !busy_q);
    COV_BOTH_MARKERS: cover property (markerOut == 2'h3);

endmodule : awg_trigger_marker_unit

//--- atm_pkg.sv
// constants, opcodes and state codes of the trigger and marker unit
// assumes: shared by the unit's top module, its trigger channels and their interface
package atm_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ANALOG_W = 14;
    localparam int MARKER_W = 2;
    localparam int NUM_TRIG = 4;
    localparam int ARG_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // register offsets and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CHAN_CFG0 = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_SLOPE_LSB = 4;
    localparam int ST_TRIG_LSB = 0;
    localparam int ST_MARK_LSB = 4;
    localparam int ST_BUSY_BIT = 6;
    localparam int ST_WEDGE_BIT = 7;
    localparam int ST_WEND_BIT = 8;
    localparam int ST_WCYC_BIT = 9;

    // ------------------------------------------------------------------
    // slope selection, instructions, sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SLOPE_OFF = 2'h0,
        SLOPE_RISE = 2'h1,
        SLOPE_FALL = 2'h2,
        SLOPE_BOTH = 2'h3
    } atm_slope_t;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_WAIT_EDGE = 3'h1,
        OP_LOAD_TRIG = 3'h2,
        OP_WAIT_END = 3'h3,
        OP_START_PLAY = 3'h4,
        OP_WAIT_CYC = 3'h5
    } atm_op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT_EDGE = 4'h2,
        ST_WAIT_END = 4'h4,
        ST_WAIT_CYC = 4'h8
    } atm_state_t;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] RST_TRIG_OUT = 4'h0;
    localparam logic [1:0] RST_MARKER = 2'h0;
    localparam atm_slope_t RST_SLOPE = SLOPE_RISE;

endpackage : atm_pkg

//--- atm_trig_if.sv
// carrier between the unit's control logic and one trigger input channel
// assumes: instantiated once per channel by the top module
`timescale 1ns/10ps

interface atm_trig_if #(
    parameter int SELW = 3
);
    logic [SELW-1:0] srcSel;
    atm_pkg::atm_slope_t slope;
    logic edgeSeen;

    modport chan (input srcSel, input slope, output edgeSeen);
    modport ctrl (output srcSel, output slope, input edgeSeen);
endinterface : atm_trig_if

//--- atm_trig_channel.sv
// one trigger input channel: source mux and slope-qualified edge detector
// assumes: source levels are already in the clk domain
`timescale 1ns/10ps

module atm_trig_channel #(
    parameter int NSRC = 8,
    parameter int SELW = 3
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [NSRC-1:0] srcLevels,
    atm_trig_if.chan tif
);

    logic level;
    logic prev_q;
    logic prev_d;
    logic rise;
    logic fall;

    // source mux; out-of-range select reads as a quiet low source
    always_comb begin
        level = 1'b0;
        if (int'(tif.srcSel) < NSRC) begin
            level = srcLevels[tif.srcSel];
        end
    end

    // previous level for edge detection
    always_comb begin
        prev_d = level;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end

    // slope qualification; a source switch may itself look like an edge
    assign rise = level & ~prev_q;
    assign fall = ~level & prev_q;

    always_comb begin
        case (tif.slope)
            atm_pkg::SLOPE_RISE: tif.edgeSeen = rise;
            atm_pkg::SLOPE_FALL: tif.edgeSeen = fall;
            atm_pkg::SLOPE_BOTH: tif.edgeSeen = rise | fall;
            default: tif.edgeSeen = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    AST_RISE_ONLY_LOW_TO_HIGH: assert property (@(posedge clk) disable iff (srst)
        (tif.slope == atm_pkg::SLOPE_RISE && tif.edgeSeen) |-> (level && !prev_q))
        else $error("rise event without low to high transition");

    AST_SELECTED_SOURCE: assert property (@(posedge clk) disable iff (srst)
        (tif.slope == atm_pkg::SLOPE_RISE && $stable(tif.srcSel) && int'(tif.srcSel) < NSRC
         && srcLevels[tif.srcSel] && !$past(srcLevels[tif.srcSel])) |-> tif.edgeSeen)
        else $error("edge on selected source missed");

endmodule : atm_trig_channel

//--- atm_play_model.sv
// playback engine stand-in: streams a six-word waveform after each start pulse
// assumes: playStart is sampled at the rising edge; slow adds an idle cycle per word
`timescale 1ns/10ps

module atm_play_model #(
    parameter int LEN = 6
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic slow,
    input wire logic playStart,
    output logic wordValid,
    output logic [atm_pkg::WORD_W-1:0] wordData,
    output logic wordLast
);
    logic active_q;
    logic phase_q;
    logic [2:0] idx_q;
    logic [15:0] prev_q;

    // analog wave has clear markers, marker wave has zero analog, the sum merges both
    function automatic logic [15:0] word_at(input logic [2:0] i);
        logic [15:0] base;
        logic [15:0] mark;
        base = {14'h0123 + 14'(i), 2'h0};
        mark = {14'h0000, i[1:0]};
        return {base[15:2] + mark[15:2], base[1:0] | mark[1:0]};
    endfunction : word_at

    // idle data lines show the inverse of the last word so no stale copy can pass
    assign wordValid = active_q && (!slow || phase_q);
    assign wordLast = wordValid && (idx_q == 3'(LEN - 1));
    assign wordData = wordValid ? word_at(idx_q) : ~prev_q;

    // word counter, restarted by every start pulse
    always @(posedge clk) begin
        if (srst) begin
            active_q <= 1'b0;
            phase_q <= 1'b0;
            idx_q <= 3'h0;
            prev_q <= 16'h0000;
        end else begin
            phase_q <= ~phase_q;
            if (playStart) begin
                active_q <= 1'b1;
                idx_q <= 3'h0;
            end else if (wordValid) begin
                idx_q <= idx_q + 3'h1;
                prev_q <= wordData;
                if (wordLast) begin
                    active_q <= 1'b0;
                end
            end
        end
    end
endmodule : atm_play_model

//--- awg_trigger_marker_unit_test.sv
// self-checking bench for the trigger and marker unit
// assumes: atm_pkg and atm_play_model compiled first; one 10 MHz clock
`timescale 1ns/10ps

module awg_trigger_marker_unit_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [31:0] regRdData;
    logic [3:0] extTrigPins = 4'h0;
    logic [3:0] intTrigSrc = 4'h0;
    logic instrValid = 1'b0;
    atm_pkg::atm_op_t instrOp = atm_pkg::OP_NOP;
    logic [15:0] instrArg = 16'h0;
    logic instrReady, playStart, wordValid, wordLast;
    logic [15:0] wordData;
    logic [13:0] analogOut;
    logic [1:0] markerOut;
    logic [3:0] triggerOut;
    logic slow = 1'b0;
    logic seenV = 1'b0;
    logic [15:0] seenW = 16'h0;
    logic firstArm = 1'b0;
    logic firstHit = 1'b0;
    logic lastSeen = 1'b0;
    logic [3:0] pats [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3};
    logic [31:0] cfg;
    int n_mismatch = 0;
    int check_count = 0;
    int nPlay = 0;
    int n;
    int base;

    initial forever #50 clk = ~clk;

    awg_trigger_marker_unit i_dut (.clk(clk), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .extTrigPins(extTrigPins), .intTrigSrc(intTrigSrc), .instrValid(instrValid),
        .instrOp(instrOp), .instrArg(instrArg), .instrReady(instrReady),
        .playStart(playStart), .wordValid(wordValid), .wordData(wordData),
        .wordLast(wordLast), .analogOut(analogOut), .markerOut(markerOut),
        .triggerOut(triggerOut));

    atm_play_model i_play (.clk(clk), .srst(srst), .slow(slow), .playStart(playStart),
        .wordValid(wordValid), .wordData(wordData), .wordLast(wordLast));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    // register cycles start right after a rising edge and end on one
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        chk(regRdData, e);
        @(posedge clk);
    endtask : rd

    task automatic post(input atm_pkg::atm_op_t op, input logic [15:0] arg);
        instrValid <= 1'b1;
        instrOp <= op;
        instrArg <= arg;
    endtask : post

    // ready is sampled mid-cycle; the request is held up to the taking edge
    task automatic waitTake();
        n = 0;
        @(negedge clk);
        while (instrReady !== 1'b1) begin
            n++;
            if (n > 300) begin
                n_mismatch++;
                results();
            end
            @(negedge clk);
        end
        @(posedge clk);
    endtask : waitTake

    task automatic send(input atm_pkg::atm_op_t op, input logic [15:0] arg);
        post(op, arg);
        waitTake();
    endtask : send

    task automatic setSrc(input int i, input logic v);
        if (i == 0) begin
            extTrigPins[0] <= v;
        end else begin
            intTrigSrc[i] <= v;
        end
    endtask : setSrc

    // word monitor: each registered word must show up whole on the outputs
    always @(posedge clk) begin
        seenV <= wordValid;
        seenW <= wordData;
        firstHit <= wordValid && firstArm;
        // only the slow playback is watched for its first word and its end
        if (playStart && slow) begin
            firstArm <= 1'b1;
            lastSeen <= 1'b0;
        end else if (wordValid) begin
            firstArm <= 1'b0;
        end
        if (wordValid && wordLast) begin
            lastSeen <= 1'b1;
        end
    end

    always @(negedge clk) begin
        if (seenV) begin
            chk(analogOut, seenW[15:2]);
            chk(markerOut, seenW[1:0]);
        end
        if (firstHit) begin
            chk(triggerOut, 4'hA);
        end
        if (wordValid && firstArm) begin
            chk(triggerOut, 4'h3);
        end
        if (playStart === 1'b1) begin
            nPlay++;
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk(triggerOut, 4'h0);
        chk(markerOut, 2'h0);
        chk(instrReady, 1'b1);
        @(posedge clk);
        rd(atm_pkg::OFS_STATUS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            rd(8'(i), 32'(atm_pkg::RST_SLOPE) << atm_pkg::CFG_SLOPE_LSB);
        end
        wr(atm_pkg::OFS_STATUS, 32'hFFFF_FFFF);
        rd(atm_pkg::OFS_STATUS, 32'h0);
        rd(8'h20, 32'h0);
        // plain loads become visible two cycles after being taken
        for (int i = 0; i < 5; i++) begin
            send(atm_pkg::OP_LOAD_TRIG, 16'(pats[i]));
            send(atm_pkg::OP_NOP, 16'h0);
            instrValid <= 1'b0;
            @(negedge clk);
            chk(triggerOut, pats[i]);
            @(posedge clk);
        end
        rd(atm_pkg::OFS_STATUS, 32'h3);
        send(atm_pkg::OP_WAIT_CYC, 16'h3);
        send(atm_pkg::OP_NOP, 16'h0);
        instrValid <= 1'b0;
        chk(n, 3);
        // each start waits for its own edge; channel 0 uses a pin, 2 both slopes, 3 falling
        for (int i = 0; i < 4; i++) begin
            cfg = (i == 3) ? 32'h20 : ((i == 2) ? 32'h30 : 32'h10);
            cfg = cfg | ((i == 0) ? 32'h0 : 32'(4 + i));
            wr(8'(i), cfg);
            rd(8'(i), cfg);
            base = nPlay;
            send(atm_pkg::OP_WAIT_EDGE, 16'(i));
            post(atm_pkg::OP_START_PLAY, 16'h0);
            // status shows the edge wait; markers hold the last word of the previous playback
            rd(atm_pkg::OFS_STATUS, (i == 0) ? 32'h83 : 32'h93);
            @(negedge clk);
            chk(instrReady, 1'b0);
            @(posedge clk);
            setSrc(i, 1'b1);
            if (i == 3) begin
                repeat (6) @(negedge clk);
                chk(nPlay, base);
                @(posedge clk);
                setSrc(i, 1'b0);
            end
            chk(nPlay, base);
            waitTake();
            chk(nPlay, base + 1);
            send(atm_pkg::OP_WAIT_END, 16'h0);
            send(atm_pkg::OP_NOP, 16'h0);
            instrValid <= 1'b0;
            setSrc(i, 1'b0);
        end
        // aligned load with a slow engine, then a load held back by the end wait
        @(posedge clk);
        slow <= 1'b1;
        send(atm_pkg::OP_LOAD_TRIG, 16'hA);
        send(atm_pkg::OP_START_PLAY, 16'h0);
        send(atm_pkg::OP_WAIT_END, 16'h0);
        chk(n, 0);
        send(atm_pkg::OP_LOAD_TRIG, 16'h0);
        chk(lastSeen, 1'b1);
        send(atm_pkg::OP_NOP, 16'h0);
        instrValid <= 1'b0;
        @(negedge clk);
        chk(triggerOut, 4'h0);
        results();
    end
endmodule : awg_trigger_marker_unit_test
